//--- common/rxd_regs.svh
`ifndef RXD_REGS_SVH
`define RXD_REGS_SVH

// Register indices; byte address is four times the index
`define RXD_CM_IDX          8'h1b
`define RXD_RM_IDX          8'h1c
`define RXD_AUTO_IDX        8'h1d

// Card-mode configuration fields
`define RXD_CM_FRM_MSB      30
`define RXD_CM_FRM_LSB      29
`define RXD_CM_TAP_MSB      28
`define RXD_CM_TAP_LSB      26
`define RXD_CM_EDGE_MSB     25
`define RXD_CM_EDGE_LSB     13
`define RXD_CM_BIT_MSB      12
`define RXD_CM_BIT_LSB      0
`define RXD_CM_MASK         32'h7fffffff
`define RXD_CM_RESET        32'h00000000

// Reader-mode configuration fields
`define RXD_RM_IQ_MSB       23
`define RXD_RM_IQ_LSB       21
`define RXD_RM_TEST_BIT     20
`define RXD_RM_RESYNC_BIT   19
`define RXD_RM_CORR_BIT     18
`define RXD_RM_FILT_BIT     17
`define RXD_RM_EARLY_BIT    16
`define RXD_RM_LVL_MSB      15
`define RXD_RM_LVL_LSB      12
`define RXD_RM_MASK         32'h00fff000
`define RXD_RM_RESET        32'h00080000

// Automatic mode detection control
`define RXD_AUTO_EN_BIT     0
`define RXD_AUTO_MASK       32'h00000001
`define RXD_AUTO_RESET      32'h00000000

// Framing codes and peer-to-peer sync byte
`define RXD_FRM_TYPE_A      2'h0
`define RXD_FRM_P2P         2'h1
`define RXD_P2P_SYNC_BYTE   8'hf0

`endif

//--- common/rxd_pkg.sv
package rxd_pkg;
   // Channel processing choice for the reader-mode demodulator
   typedef enum logic [2:0] {
      RXD_IQ_BOTH,
      RXD_IQ_I_ONLY,
      RXD_IQ_Q_ONLY,
      RXD_IQ_STRONGEST,
      RXD_IQ_FIRST
   } rxd_iq_mode_t;

   typedef logic [12:0] rxd_thr_t;   // Decision threshold word
   typedef logic [3:0]  rxd_lvl_t;   // Subcarrier threshold value
   typedef logic [5:0]  rxd_taps_t;  // Edge filter tap count
endpackage : rxd_pkg

//--- logic/rxd_tap_decode.sv
`timescale 1ns/10ps
module rxd_tap_decode (
   input  wire logic [2:0]        i_tap_sel,
   output rxd_pkg::rxd_taps_t     o_taps
);
   import rxd_pkg::*;

   // Tap count from the three-bit select; codes 010 and 011 both give 8
   function automatic rxd_taps_t rxd_taps(input logic [2:0] sel);
      case (sel)
         3'h0:    rxd_taps = 6'h04;
         3'h1:    rxd_taps = 6'h06;
         3'h2:    rxd_taps = 6'h08;
         3'h3:    rxd_taps = 6'h08;
         3'h4:    rxd_taps = 6'h10;
         3'h5:    rxd_taps = 6'h12;
         3'h6:    rxd_taps = 6'h18;
         default: rxd_taps = 6'h20;
      endcase
   endfunction : rxd_taps

   assign o_taps = rxd_taps(i_tap_sel);
endmodule : rxd_tap_decode

//--- logic/rxd_demod_cfg.sv
// Local design decision: the APB register port.
`timescale 1ns/10ps
`include "rxd_regs.svh"

////////////////////////////////////////////////////////////////////////////
module rxd_demod_cfg #(
   parameter int CORR_W = 16                 // Correlation sample width
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_resetn,
   input  wire logic                i_clk_en,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [9:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Mode detector and reception status
   input  wire logic                i_mode_det_set,
   input  wire logic [1:0]          i_mode_det_framing,
   input  wire logic                i_rx_active,
   // Card-mode demodulator metrics
   input  wire rxd_pkg::rxd_thr_t   i_edge_metric,
   input  wire rxd_pkg::rxd_thr_t   i_bit_metric,
   // Reader-mode correlations and subcarrier level
   input  wire logic [CORR_W-1:0]   i_corr_0110,
   input  wire logic [CORR_W-1:0]   i_corr_1110,
   input  wire logic [CORR_W-1:0]   i_corr_0111,
   input  wire rxd_pkg::rxd_lvl_t   i_subc_level,
   input  wire logic [2:0]          i_lvl_adjust,
   // Configuration towards the demodulator
   output logic                     o_framing_type_a,
   output logic                     o_framing_p2p,
   output logic [7:0]               o_sync_byte,
   output rxd_pkg::rxd_taps_t       o_edge_taps,
   output logic                     o_edge_hit,
   output logic                     o_bit_hit,
   output rxd_pkg::rxd_iq_mode_t    o_iq_mode,
   output logic                     o_sof_resync_en,
   output logic                     o_corr_clear_en,
   output logic                     o_test_filter_bit,
   output logic                     o_early_data_en,
   output logic [CORR_W+1:0]        o_corr_filtered,
   output rxd_pkg::rxd_lvl_t        o_subc_threshold,
   output logic                     o_subc_present
);
   import rxd_pkg::*;

   // Narrow widths below two bits leave no room for the filter sum
   if (CORR_W < 2) begin : g_bad_width
      $error("CORR_W must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Threshold comparison shared by both decision stages
   function automatic logic rxd_reaches(input rxd_thr_t metric,
                                        input rxd_thr_t thr);
      rxd_reaches = (metric >= thr);
   endfunction : rxd_reaches

   // Sign-magnitude adjust, clamped to the four-bit range
   function automatic rxd_lvl_t rxd_lvl_adj(input rxd_lvl_t base,
                                            input logic [2:0] adj);
      logic [4:0] sum;
      sum = {1'b0, base};
      if (adj[2]) begin
         sum = (sum < {3'h0, adj[1:0]}) ? 5'h00 : sum - {3'h0, adj[1:0]};
      end else begin
         sum = sum + {3'h0, adj[1:0]};
      end
      rxd_lvl_adj = sum[4] ? 4'hf : sum[3:0];
   endfunction : rxd_lvl_adj

   ////////////////////////////////////////////////////////////////////////
   // Register state

   logic [31:0]   cm_r;          // Card-mode configuration as written
   logic [31:0]   rm_r;          // Reader-mode configuration as written
   logic [31:0]   auto_r;        // Automatic mode detection control
   logic [31:0]   cm_act_r;      // Copy in use by the running reception
   logic [31:0]   rm_act_r;      // Copy in use by the running reception
   logic          hit_cm;        // Address decodes
   logic          hit_rm;
   logic          hit_auto;
   logic          hit_any;
   logic          wr_go;         // Write takes effect this edge
   logic          mode_ovr;      // Mode detector overrides framing
   logic [31:0]   rd_nxt;        // Read data for the setup phase
   rxd_taps_t     taps_dec;      // Tap count of the active select

   ////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states

   assign hit_cm   = (paddr[9:2] == `RXD_CM_IDX);
   assign hit_rm   = (paddr[9:2] == `RXD_RM_IDX);
   assign hit_auto = (paddr[9:2] == `RXD_AUTO_IDX);
   assign hit_any  = hit_cm | hit_rm | hit_auto;
   assign pready   = 1'b1;
   // Unmapped addresses answer with an error, reads return zero
   assign pslverr  = psel & penable & ~hit_any;
   assign wr_go    = psel & penable & pwrite & i_clk_en;
   assign mode_ovr = auto_r[`RXD_AUTO_EN_BIT] & i_mode_det_set;

   // Card-mode register; with auto detection on, detector framing wins over a software write, other fields still store
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cm_r <= `RXD_CM_RESET;
      end else if (i_clk_en) begin
         if (mode_ovr) begin
            cm_r[`RXD_CM_FRM_MSB:`RXD_CM_FRM_LSB] <= i_mode_det_framing;
            if (wr_go && hit_cm) begin
               cm_r[`RXD_CM_TAP_MSB:0] <= pwdata[`RXD_CM_TAP_MSB:0];
            end
         end else if (wr_go && hit_cm) begin
            cm_r <= pwdata & `RXD_CM_MASK;
         end
      end
   end

   // Reader-mode register; reserved bits never store
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rm_r <= `RXD_RM_RESET;
      end else if (wr_go && hit_rm) begin
         rm_r <= pwdata & `RXD_RM_MASK;
      end
   end

   // Automatic mode detection enable
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         auto_r <= `RXD_AUTO_RESET;
      end else if (wr_go && hit_auto) begin
         auto_r <= pwdata & `RXD_AUTO_MASK;
      end
   end

   // Read data captured in the setup phase so it stands from a flop
   always_comb begin
      rd_nxt = 32'h00000000;
      if (hit_cm) begin
         rd_nxt = cm_r;
      end else if (hit_rm) begin
         rd_nxt = rm_r;
      end else if (hit_auto) begin
         rd_nxt = auto_r;
      end
   end

   // Read data register
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prdata <= 32'h00000000;
      end else if (i_clk_en && psel && !penable && !pwrite) begin
         prdata <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Active copies: a frame in progress never sees a half-changed setup

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cm_act_r <= `RXD_CM_RESET;
         rm_act_r <= `RXD_RM_RESET;
      end else if (i_clk_en && !i_rx_active) begin
         cm_act_r <= cm_r;
         rm_act_r <= rm_r;
      end
   end

   rxd_tap_decode u_tap_decode (
      .i_tap_sel (cm_act_r[`RXD_CM_TAP_MSB:`RXD_CM_TAP_LSB]),
      .o_taps    (taps_dec)
   );

   ////////////////////////////////////////////////////////////////////////
   // Card-mode outputs

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_framing_type_a <= 1'b1;
         o_framing_p2p    <= 1'b0;
         o_sync_byte      <= 8'h00;
         o_edge_taps      <= 6'h04;
         o_edge_hit       <= 1'b0;
         o_bit_hit        <= 1'b0;
      end else if (i_clk_en) begin
         // Codes 10 and 11 select neither framing
         o_framing_type_a <= (cm_act_r[`RXD_CM_FRM_MSB:`RXD_CM_FRM_LSB]
                              == `RXD_FRM_TYPE_A);
         o_framing_p2p    <= (cm_act_r[`RXD_CM_FRM_MSB:`RXD_CM_FRM_LSB]
                              == `RXD_FRM_P2P);
         o_sync_byte      <= (cm_act_r[`RXD_CM_FRM_MSB:`RXD_CM_FRM_LSB]
                              == `RXD_FRM_P2P) ? `RXD_P2P_SYNC_BYTE
                                               : 8'h00;
         o_edge_taps      <= taps_dec;
         o_edge_hit       <= rxd_reaches(i_edge_metric,
            cm_act_r[`RXD_CM_EDGE_MSB:`RXD_CM_EDGE_LSB]);
         o_bit_hit        <= rxd_reaches(i_bit_metric,
            cm_act_r[`RXD_CM_BIT_MSB:`RXD_CM_BIT_LSB]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reader-mode outputs

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_iq_mode <= RXD_IQ_BOTH;
      end else if (i_clk_en) begin
         // Reserved codes fall back to using both channels
         case (rm_act_r[`RXD_RM_IQ_MSB:`RXD_RM_IQ_LSB])
            3'h1:    o_iq_mode <= RXD_IQ_I_ONLY;
            3'h2:    o_iq_mode <= RXD_IQ_Q_ONLY;
            3'h4:    o_iq_mode <= RXD_IQ_STRONGEST;
            3'h5:    o_iq_mode <= RXD_IQ_FIRST;
            default: o_iq_mode <= RXD_IQ_BOTH;
         endcase
      end
   end

   // Enable bits for the correlator and start-of-frame logic
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sof_resync_en   <= 1'b1;
         o_corr_clear_en   <= 1'b0;
         o_test_filter_bit <= 1'b0;
         o_early_data_en   <= 1'b0;
      end else if (i_clk_en) begin
         o_sof_resync_en   <= rm_act_r[`RXD_RM_RESYNC_BIT];
         o_corr_clear_en   <= rm_act_r[`RXD_RM_CORR_BIT];
         o_test_filter_bit <= rm_act_r[`RXD_RM_TEST_BIT];
         o_early_data_en   <= rm_act_r[`RXD_RM_EARLY_BIT];
      end
   end

   // Pattern filter: 0110 less the mean of its two neighbours
   logic signed [CORR_W+1:0] c0110_x;   // Sign-extended correlations
   logic signed [CORR_W+1:0] nsum_x;
   assign c0110_x = (CORR_W+2)'(signed'(i_corr_0110));
   assign nsum_x  = (CORR_W+2)'(signed'(i_corr_1110))
                  + (CORR_W+2)'(signed'(i_corr_0111));

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_corr_filtered <= '0;
      end else if (i_clk_en) begin
         if (rm_act_r[`RXD_RM_FILT_BIT]) begin
            o_corr_filtered <= c0110_x;
         end else begin
            o_corr_filtered <= c0110_x - (nsum_x >>> 1);
         end
      end
   end

   // Subcarrier threshold after tuning adjustment, and detection
   rxd_lvl_t lvl_eff;                    // Adjusted threshold
   assign lvl_eff = rxd_lvl_adj(rm_act_r[`RXD_RM_LVL_MSB:`RXD_RM_LVL_LSB],
                                i_lvl_adjust);

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_subc_threshold <= 4'h0;
         o_subc_present   <= 1'b0;
      end else if (i_clk_en) begin
         o_subc_threshold <= lvl_eff;
         // Level must exceed the threshold, never merely meet it
         o_subc_present   <= (i_subc_level > lvl_eff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_mode_override: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en && mode_ovr |=>
      cm_r[`RXD_CM_FRM_MSB:`RXD_CM_FRM_LSB] == $past(i_mode_det_framing))
      else $error("mode detector framing not stored");

   a_sync_byte: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en |=>
      (o_sync_byte == 8'hf0) == $past(cm_act_r[30:29] == 2'h1))
      else $error("sync byte does not follow framing");

   a_tap_count: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en && cm_act_r[28:26] == 3'h5 |=>
      o_edge_taps == 6'h12)
      else $error("tap count wrong for select 101");

   a_edge_compare: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_resetn && i_clk_en |=>
      o_edge_hit == ($past(i_edge_metric) >= $past(cm_act_r[25:13])))
      else $error("edge decision mismatch");

   a_bit_compare: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_resetn && i_clk_en |=>
      o_bit_hit == ($past(i_bit_metric) >= $past(cm_act_r[12:0])))
      else $error("bit decision mismatch");

   a_iq_strongest: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en && rm_act_r[23:21] == 3'h4 |=>
      o_iq_mode == RXD_IQ_STRONGEST)
      else $error("iq select not decoded");

   a_filter_bypass: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en && rm_act_r[17] |=>
      o_corr_filtered == $past(c0110_x))
      else $error("filter not bypassed");

   a_early_data: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_clk_en |=>
      o_early_data_en == $past(rm_act_r[16]))
      else $error("early data enable wrong");

   a_level_clamp: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) !i_lvl_adjust[2] &&
      rm_act_r[15:12] > 4'hf - {2'h0, i_lvl_adjust[1:0]} |-> lvl_eff == 4'hf)
      else $error("threshold adjust overflowed");

   a_cfg_frozen: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) i_rx_active ##1 i_rx_active |->
      $stable(cm_act_r) && $stable(rm_act_r))
      else $error("active setup changed during reception");

   a_reserved_zero: assert property (@(posedge i_sys_clk)
      disable iff (!i_resetn) 1'b1 |-> cm_r[31] == 1'b0 &&
      rm_r[31:24] == 8'h00 && rm_r[11:0] == 12'h000)
      else $error("reserved bits stored");
endmodule : rxd_demod_cfg

//--- testbench/rxd_demod_cfg_bench.sv
`timescale 1ns/10ps
`include "rxd_regs.svh"

module rxd_demod_cfg_bench;
   import rxd_pkg::*;

   localparam int         CW    = 16;                  // Correlation width
   localparam logic [9:0] A_CM  = {`RXD_CM_IDX, 2'b00};
   localparam logic [9:0] A_RM  = {`RXD_RM_IDX, 2'b00};
   localparam logic [9:0] A_AU  = {`RXD_AUTO_IDX, 2'b00};
   localparam int         TAPS [8] = '{4, 6, 8, 8, 16, 18, 24, 32};

   logic          i_sys_clk, i_resetn, i_clk_en;      // Clock and control
   logic          psel, penable, pwrite;              // APB request
   logic [9:0]    paddr;                              // APB byte address
   logic [31:0]   pwdata, prdata;                     // APB data
   logic          pready, pslverr;                    // APB answer
   logic          i_mode_det_set, i_rx_active;        // Detector, rx state
   logic [1:0]    i_mode_det_framing;                 // Detected framing
   rxd_thr_t      i_edge_metric, i_bit_metric;        // Decision metrics
   logic [CW-1:0] i_corr_0110, i_corr_1110, i_corr_0111;
   rxd_lvl_t      i_subc_level, o_subc_threshold;     // Subcarrier level
   logic [2:0]    i_lvl_adjust;                       // Signed adjustment
   logic          o_framing_type_a, o_framing_p2p;    // Framing outputs
   logic          o_edge_hit, o_bit_hit;              // Decisions
   logic [7:0]    o_sync_byte;                        // Sync pattern
   rxd_taps_t     o_edge_taps;                        // Filter length
   rxd_iq_mode_t  o_iq_mode;                          // Channel choice
   logic          o_sof_resync_en, o_corr_clear_en;   // Reader flags
   logic          o_test_filter_bit, o_early_data_en; // Reader flags
   logic          o_subc_present;                     // Carrier seen
   logic [CW+1:0] o_corr_filtered;                    // Filtered corr
   int            n_errors, n_checks;                 // Report counters
   logic [31:0]   seed, rd, d, r, last_rm;            // Scratch words
   logic          err;                                // Last pslverr

   ////////////////////////////////////////////////////////////////////////
   rxd_demod_cfg #(.CORR_W(CW)) uut (
      .i_sys_clk, .i_resetn, .i_clk_en, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .i_mode_det_set,
      .i_mode_det_framing, .i_rx_active, .i_edge_metric, .i_bit_metric,
      .i_corr_0110, .i_corr_1110, .i_corr_0111, .i_subc_level,
      .i_lvl_adjust, .o_framing_type_a, .o_framing_p2p, .o_sync_byte,
      .o_edge_taps, .o_edge_hit, .o_bit_hit, .o_iq_mode, .o_sof_resync_en,
      .o_corr_clear_en, .o_test_filter_bit, .o_early_data_en,
      .o_corr_filtered, .o_subc_threshold, .o_subc_present
   );

   // Free-running 100 MHz clock
   initial i_sys_clk = 1'b0;
   always #5 i_sys_clk = ~i_sys_clk;

   ////////////////////////////////////////////////////////////////////////
   // Repeatable xorshift source, seeded at 2
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // Channel choice; undefined codes fall back to both channels
   function automatic rxd_iq_mode_t iqx(input logic [2:0] c);
      case (c)
         3'h1:    return RXD_IQ_I_ONLY;
         3'h2:    return RXD_IQ_Q_ONLY;
         3'h4:    return RXD_IQ_STRONGEST;
         3'h5:    return RXD_IQ_FIRST;
         default: return RXD_IQ_BOTH;
      endcase
   endfunction : iqx

   // Level plus sign/magnitude step, clamped to the 4-bit range
   function automatic rxd_lvl_t adj(input rxd_lvl_t v, input logic [2:0] a);
      int s;
      s = a[2] ? int'(v) - int'(a[1:0]) : int'(v) + int'(a[1:0]);
      return (s < 0) ? 4'h0 : (s > 15) ? 4'hf : rxd_lvl_t'(s);
   endfunction : adj

   // Pattern filter from the current correlation inputs
   function automatic logic [CW+1:0] filt(input logic off);
      int a, b, c;
      a = $signed(i_corr_0110);
      b = $signed(i_corr_1110);
      c = $signed(i_corr_0111);
      return (CW+2)'(off ? a : a - ((b + c) >>> 1));
   endfunction : filt

   ////////////////////////////////////////////////////////////////////////
   // One comparison, counted; four-state so unknowns never match
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready seen at an edge
   task automatic apb(input logic w, input logic [9:0] a,
                      input logic [31:0] wd);
      @(posedge i_sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      do @(posedge i_sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Read a register and compare it
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp,
                      input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rdc

   // Let config reach the outputs; sample away from the edge
   task automatic settle();
      repeat (4) @(posedge i_sys_clk);
      #1;
   endtask : settle

   // Mode detector reports one framing code
   task automatic det(input logic [1:0] f);
      @(posedge i_sys_clk);
      i_mode_det_set     <= 1'b1;
      i_mode_det_framing <= f;
      @(posedge i_sys_clk);
      i_mode_det_set     <= 1'b0;
   endtask : det

   // Report counts and verdict, then stop
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////
   // Watchdog; whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      n_errors++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      seed = 32'h2;
      n_errors = 0;
      n_checks = 0;
      {i_resetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {i_mode_det_set, i_mode_det_framing, i_rx_active} = '0;
      {i_edge_metric, i_bit_metric, i_subc_level, i_lvl_adjust} = '0;
      {i_corr_0110, i_corr_1110, i_corr_0111} = '0;
      i_clk_en = 1'b1;
      repeat (12) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      settle();
      // Reset values of registers and outputs
      rdc(A_CM, `RXD_CM_RESET, "cm reset");
      rdc(A_RM, `RXD_RM_RESET, "rm reset");
      rdc(A_AU, `RXD_AUTO_RESET, "auto reset");
      chk(o_framing_type_a, 1, "reset framing");
      chk(o_edge_taps, 4, "reset taps");
      chk(o_iq_mode, RXD_IQ_BOTH, "reset iq");
      chk(o_sof_resync_en, 1, "reset resync");
      chk(o_corr_clear_en, 0, "reset corr clear");
      // Unmapped place: error, reads zero
      apb(1'b1, 10'h078, 32'hffffffff);
      chk(err, 1, "unmapped write");
      apb(1'b0, 10'h078, 32'h0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
      // Card mode: every tap and framing code, thresholds at the edge
      for (int i = 0; i < 8; i++) begin
         d = xs();
         d[28:26] = 3'(i);
         d[30:29] = 2'(i);
         apb(1'b1, A_CM, d);
         rdc(A_CM, d & `RXD_CM_MASK, "cm readback");
         @(posedge i_sys_clk);
         i_edge_metric <= d[25:13] - 13'(i % 2);
         i_bit_metric  <= d[12:0] - 13'(i / 2 % 2);
         settle();
         chk(o_framing_type_a, d[30:29] == 2'h0, "type a");
         chk(o_framing_p2p, d[30:29] == 2'h1, "p2p");
         chk(o_sync_byte, d[30:29] == 2'h1 ? 8'hf0 : 8'h0, "sync");
         chk(o_edge_taps, TAPS[i], "taps");
         chk(o_edge_hit, i_edge_metric >= d[25:13], "edge");
         chk(o_bit_hit, i_bit_metric >= d[12:0], "bit");
      end
      // Reader mode: every channel code, filter, clamped levels
      for (int i = 0; i < 8; i++) begin
         d = xs();
         d[23:21] = 3'(i);
         d[17] = i[0];
         d[15:12] = (i < 4) ? 4'he : 4'h1;
         last_rm = d & `RXD_RM_MASK;
         apb(1'b1, A_RM, d);
         rdc(A_RM, last_rm, "rm readback");
         r = xs();
         @(posedge i_sys_clk);
         i_corr_0110  <= r[15:0];
         i_corr_1110  <= r[31:16];
         i_corr_0111  <= r[23:8];
         i_subc_level <= r[3:0];
         i_lvl_adjust <= 3'(i);
         settle();
         chk(o_iq_mode, iqx(3'(i)), "iq");
         chk(o_test_filter_bit, d[20], "test bit");
         chk(o_sof_resync_en, d[19], "resync");
         chk(o_corr_clear_en, d[18], "corr clear");
         chk(o_corr_filtered, filt(d[17]), "filter");
         chk(o_early_data_en, d[16], "early data");
         r[3:0] = adj(d[15:12], 3'(i));
         chk(o_subc_threshold, r[3:0], "threshold");
         chk(o_subc_present, i_subc_level > r[3:0], "present");
      end
      // Write while clock enable is low is lost
      @(posedge i_sys_clk);
      i_clk_en <= 1'b0;
      apb(1'b1, A_RM, ~last_rm);
      @(posedge i_sys_clk);
      i_clk_en <= 1'b1;
      rdc(A_RM, last_rm, "frozen write");
      // Changes wait until reception ends
      apb(1'b1, A_CM, 32'h0c00abcd);
      settle();
      @(posedge i_sys_clk);
      i_rx_active <= 1'b1;
      apb(1'b1, A_CM, 32'h2c00abcd);
      settle();
      chk(o_framing_type_a, 1, "held in rx");
      @(posedge i_sys_clk);
      i_rx_active <= 1'b0;
      settle();
      chk(o_framing_p2p, 1, "after rx");
      // Detector ignored while automatic detection is off
      det(2'h0);
      rdc(A_CM, 32'h2c00abcd, "det ignored");
      apb(1'b1, A_AU, 32'hffffffff);
      rdc(A_AU, `RXD_AUTO_MASK, "auto on");
      det(2'h0);
      rdc(A_CM, 32'h0c00abcd, "det type a");
      settle();
      chk(o_framing_type_a, 1, "det out a");
      det(2'h1);
      rdc(A_CM, 32'h2c00abcd, "det p2p");
      settle();
      chk(o_sync_byte, 8'hf0, "det sync");
      // Detector and software write meet at one edge: detector framing wins
      fork
         apb(1'b1, A_CM, 32'h3c00abcd);
         begin
            @(posedge i_sys_clk);
            det(2'h0);
         end
      join
      rdc(A_CM, 32'h1c00abcd, "det beats write");
      // Mid-run reset brings the card-mode and auto registers back
      @(posedge i_sys_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      settle();
      rdc(A_CM, `RXD_CM_RESET, "cm re-reset");
      rdc(A_AU, `RXD_AUTO_RESET, "auto re-reset");
      chk(o_sync_byte, 8'h00, "re-reset sync");
      wrap_up();
   end
endmodule : rxd_demod_cfg_bench
